/* File: design/dsp_pkg.sv */
package dsp_pkg;

  // Channel count and data width
  localparam int NCH = 3;
  localparam int DW = 16;

  // Register word indices on the Avalon word address
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_COUNT = 3'h1;
  localparam logic [2:0] REG_CMPA = 3'h2;
  localparam logic [2:0] REG_CMPB = 3'h3;
  localparam logic [2:0] REG_CMPC = 3'h4;
  localparam logic [2:0] REG_CAPTOP = 3'h5;
  localparam logic [2:0] REG_FLAGS = 3'h6;
  localparam logic [2:0] REG_PINDIR = 3'h7;

  // Control register fields
  localparam int WGM_LSB = 0;
  localparam int CS_LSB = 4;
  localparam int COM_LSB = 8;

  // Flag register bit positions
  localparam int FLG_OVF = 0;
  localparam int FLG_CMP_LSB = 1;
  localparam int FLG_CAP = 4;

  // Waveform mode encodings
  localparam logic [3:0] WGM_PC_8 = 4'h1;
  localparam logic [3:0] WGM_PC_9 = 4'h2;
  localparam logic [3:0] WGM_PC_10 = 4'h3;
  localparam logic [3:0] WGM_PFC_CAP = 4'h8;
  localparam logic [3:0] WGM_PFC_CMPA = 4'h9;
  localparam logic [3:0] WGM_PC_CAP = 4'hA;
  localparam logic [3:0] WGM_PC_CMPA = 4'hB;

  // Compare output modes
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOG = 2'h1;
  localparam logic [1:0] COM_NINV = 2'h2;
  localparam logic [1:0] COM_INV = 2'h3;

  // Prescaler selects and tap masks
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [9:0] PRE_M8 = 10'h007;
  localparam logic [9:0] PRE_M64 = 10'h03F;
  localparam logic [9:0] PRE_M256 = 10'h0FF;
  localparam logic [9:0] PRE_M1024 = 10'h3FF;

  // Fixed tops and limits
  localparam logic [15:0] TOP_8 = 16'h00FF;
  localparam logic [15:0] TOP_9 = 16'h01FF;
  localparam logic [15:0] TOP_10 = 16'h03FF;
  localparam logic [15:0] TOP_MIN = 16'h0003;
  localparam logic [15:0] BOTTOM = 16'h0000;

  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Count direction
  typedef enum logic {DSP_UP = 1'b0, DSP_DOWN = 1'b1} dsp_dir_t;

  // Avalon-MM request bundle
  typedef struct packed {
    logic read;
    logic write;
    logic [2:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } dsp_av_req_t;

endpackage

/* File: design/dsp_timer.sv */
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps

// Summary of operation
// - Counter runs zero up to top, then back down to zero, forever.
// - Phase correct top: modes 1,2,3 fixed; 10 capture top; 11 compare A.
// - Counter holds top for one timer tick, then counts down.
// - Output mode 2 gives non-inverted PWM, mode 3 inverted PWM.
// - Non-inverted: clear on up match, set on down match; inverted reversed.
// - Phase correct mode sets overflow flag when counter reaches zero.
// - Phase correct loads buffered compares at top, sets A or capture flag.
// - Each channel flag sets when counter equals its compare value.
// - Fixed top: compare writes zero the bits above the resolution.
// - Compare value above top never matches.
// - Compare zero gives constant low, compare top constant high (non-inverted).
// - Mode 11 with channel A output mode 1 toggles A on each match.
// - Frequency correct modes: 8 uses capture top, 9 uses compare A.
// - Frequency correct loads buffered compares at zero with overflow flag.
// - Frequency correct sets A or capture flag when counter reaches top.
// - Mode 9 with channel A output mode 1 toggles A on each match.
// - Compare output reaches the pin only while its direction bit is set.
// - Timer tick is the clock divided by 1, 8, 64, 256 or 1024.
// - Register-defined top is at least 3 and may reach 16 bits.
// - Output mode 0 disconnects the compare output; pin keeps port function.
module dsp_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input dsp_pkg::dsp_av_req_t av_req,
  output logic av_waitrequest,
  output logic [31:0] av_readdata,
  // Port pins
  input wire logic [dsp_pkg::NCH-1:0] port_data,
  output logic [dsp_pkg::NCH-1:0] pin_out,
  output logic [dsp_pkg::NCH-1:0] pin_oe
);
  import dsp_pkg::*;

  // Register state
  logic [15:0] ctrl_q;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] cap_top_q;
  logic [4:0] flags_q, flags_d;
  logic [NCH-1:0] dir_bits_q;
  logic [NCH-1:0] oc_q;
  logic [15:0] buf_q [NCH];
  logic [15:0] act_q [NCH];
  logic [9:0] pre_q;
  dsp_dir_t dir_q, dir_d;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [NCH-1:0] pin_out_q, pin_oe_q;

  // Field views of the control word
  wire [3:0] wgm = ctrl_q[WGM_LSB +: 4];
  wire [2:0] csel = ctrl_q[CS_LSB +: 3];
  wire is_pfc = (wgm == WGM_PFC_CAP) || (wgm == WGM_PFC_CMPA);
  wire is_pc = (wgm == WGM_PC_8) || (wgm == WGM_PC_9) || (wgm == WGM_PC_10)
    || (wgm == WGM_PC_CAP) || (wgm == WGM_PC_CMPA);
  wire dual = is_pc || is_pfc;
  wire top_cmpa = (wgm == WGM_PC_CMPA) || (wgm == WGM_PFC_CMPA);
  wire top_cap = (wgm == WGM_PC_CAP) || (wgm == WGM_PFC_CAP);
  wire fixed_top = (wgm == WGM_PC_8) || (wgm == WGM_PC_9) || (wgm == WGM_PC_10);

  // Top selection; a register top below the minimum is raised to it
  wire [15:0] reg_top = top_cap ? cap_top_q : act_q[0];
  wire [15:0] reg_top_c = (reg_top < TOP_MIN) ? TOP_MIN : reg_top;
  wire [15:0] top = (wgm == WGM_PC_8) ? TOP_8 :
                    (wgm == WGM_PC_9) ? TOP_9 :
                    (wgm == WGM_PC_10) ? TOP_10 : reg_top_c;

  // Prescaler taps; the divider runs free so a new select takes effect at once
  wire tick = (csel == CS_DIV1) ||
              ((csel == CS_DIV8) && ((pre_q & PRE_M8) == PRE_M8)) ||
              ((csel == CS_DIV64) && ((pre_q & PRE_M64) == PRE_M64)) ||
              ((csel == CS_DIV256) && ((pre_q & PRE_M256) == PRE_M256)) ||
              ((csel == CS_DIV1024) && (pre_q == PRE_M1024));

  // Turning points of the dual slope
  wire at_top = dual && tick && (cnt_q >= top);
  wire at_bot = dual && tick && (cnt_q == BOTTOM) && !at_top;
  // Direction of the step that follows this tick decides set or clear
  wire next_up = at_bot ? 1'b1 : at_top ? 1'b0 : (dir_q == DSP_UP);
  // Double-buffer load points differ between the two modes
  wire load_now = !dual || (is_pc && at_top) || (is_pfc && at_bot);

  // Bus decode
  wire acc = (av_req.read || av_req.write) && wait_q;
  wire wr = av_req.write && !wait_q;
  wire [15:0] wmask = {{8{av_req.byteenable[1]}}, {8{av_req.byteenable[0]}}};
  wire [15:0] wval = av_req.writedata[15:0];
  wire wr_ctrl = wr && (av_req.address == REG_CTRL);
  wire wr_cnt = wr && (av_req.address == REG_COUNT);
  wire wr_cap = wr && (av_req.address == REG_CAPTOP);
  wire wr_flags = wr && (av_req.address == REG_FLAGS);
  wire wr_dir = wr && (av_req.address == REG_PINDIR);
  // Fixed tops trim compare writes to the counter resolution
  wire [15:0] res_mask = fixed_top ? top : 16'hFFFF;

  // Counter next state
  always_comb begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    if (at_top) begin
      cnt_d = cnt_q - 16'h0001;
      dir_d = DSP_DOWN;
    end else if (at_bot) begin
      cnt_d = cnt_q + 16'h0001;
      dir_d = DSP_UP;
    end else if (dual && tick) begin
      cnt_d = (dir_q == DSP_UP) ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
    end
    if (wr_cnt) begin
      cnt_d = (cnt_q & ~wmask) | (wval & wmask);
    end
  end

  // Per-channel compare, flags and output level
  logic [NCH-1:0] match;
  logic [NCH-1:0] oc_d;
  logic [15:0] buf_d [NCH];
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      wire [1:0] com = ctrl_q[COM_LSB + 2*g +: 2];
      wire wr_buf = wr && (av_req.address == REG_CMPA + 3'(g));
      wire tog_ok = (g == 0) && ((wgm == WGM_PC_CMPA) || (wgm == WGM_PFC_CMPA));
      // A compare above top is never reached by the counter
      assign match[g] = dual && tick && (cnt_q == act_q[g])
        && (act_q[g] <= top);
      assign buf_d[g] = ((buf_q[g] & ~wmask) | (wval & wmask)) & res_mask;
      always_comb begin
        oc_d[g] = oc_q[g];
        if (match[g]) begin
          case (com)
            COM_NINV: oc_d[g] = !next_up;
            COM_INV: oc_d[g] = next_up;
            COM_TOG: oc_d[g] = tog_ok ? !oc_q[g] : oc_q[g];
            default: oc_d[g] = oc_q[g];
          endcase
        end
      end
      // Buffer and active compare registers
      always_ff @(posedge clk) begin
        if (rst) begin
          buf_q[g] <= RST_WORD;
          act_q[g] <= RST_WORD;
        end else begin
          if (wr_buf) begin
            buf_q[g] <= buf_d[g];
          end
          if (load_now) begin
            act_q[g] <= (wr_buf && !dual) ? buf_d[g] : buf_q[g];
          end
        end
      end
      // Pin follows the compare output only when connected; else the port value
      always_ff @(posedge clk) begin
        if (rst) begin
          pin_out_q[g] <= 1'b0;
          pin_oe_q[g] <= 1'b0;
        end else begin
          pin_out_q[g] <= (com == COM_OFF) || ((com == COM_TOG) && !tog_ok)
            ? port_data[g] : oc_d[g];
          pin_oe_q[g] <= dir_bits_q[g];
        end
      end
    end
  endgenerate

  // Flag next state: a hardware set wins over a software clear in the same cycle
  logic [4:0] flag_set;
  always_comb begin
    flag_set = 5'h00;
    flag_set[FLG_OVF] = at_bot;
    flag_set[FLG_CMP_LSB +: NCH] = match;
    if (at_top && top_cmpa) begin
      flag_set[FLG_CMP_LSB] = 1'b1;
    end
    if (at_top && top_cap) begin
      flag_set[FLG_CAP] = 1'b1;
    end
    flags_d = flags_q;
    if (wr_flags && av_req.byteenable[0]) begin
      flags_d = flags_q & ~wval[4:0];
    end
    flags_d = flags_d | flag_set;
  end

  // Read mux, captured when the request is first seen
  logic [15:0] rsel;
  always_comb begin
    case (av_req.address)
      REG_CTRL: rsel = ctrl_q;
      REG_COUNT: rsel = cnt_q;
      REG_CMPA: rsel = buf_q[0];
      REG_CMPB: rsel = buf_q[1];
      REG_CMPC: rsel = buf_q[2];
      REG_CAPTOP: rsel = cap_top_q;
      REG_FLAGS: rsel = {11'h000, flags_q};
      REG_PINDIR: rsel = {13'h0000, dir_bits_q};
      default: rsel = RST_WORD;
    endcase
  end

  // Bus handshake: one wait cycle, then waitrequest low for exactly one edge
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q <= !acc;
      if (acc) begin
        rdata_q <= {16'h0000, rsel};
      end
    end
  end

  // Control, capture top and pin direction registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= RST_WORD;
      cap_top_q <= RST_WORD;
      dir_bits_q <= '0;
    end else begin
      if (wr_ctrl) ctrl_q <= (ctrl_q & ~wmask) | (wval & wmask);
      if (wr_cap) cap_top_q <= (cap_top_q & ~wmask) | (wval & wmask);
      if (wr_dir && av_req.byteenable[0]) dir_bits_q <= wval[NCH-1:0];
    end
  end

  // Counter, direction, flags, output latches and prescaler
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= RST_WORD;
      dir_q <= DSP_UP;
      flags_q <= 5'h00;
      oc_q <= '0;
      pre_q <= 10'h000;
    end else begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
      flags_q <= flags_d;
      oc_q <= oc_d;
      pre_q <= pre_q + 10'h001;
    end
  end

  // Outputs straight from flip-flops
  assign av_waitrequest = wait_q;
  assign av_readdata = rdata_q;
  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;

endmodule // dsp_timer

/* File: test/dsp_timer_properties.sv */
`timescale 1ns/1ps
// Bus handshake and pin-enable checks seen at the timer's ports
module dsp_timer_properties
  import dsp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input dsp_pkg::dsp_av_req_t av_req,
  input wire logic av_waitrequest,
  input wire logic [31:0] av_readdata,
  // Port pins
  input wire logic [dsp_pkg::NCH-1:0] port_data,
  input wire logic [dsp_pkg::NCH-1:0] pin_out,
  input wire logic [dsp_pkg::NCH-1:0] pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Accepted direction write; the enable moves two edges later
  wire dir_wr = av_req.write && !av_waitrequest && av_req.address == REG_PINDIR
    && av_req.byteenable[0];
  a_wait_answer: assert property ((av_req.read || av_req.write) && av_waitrequest
    |=> !av_waitrequest) else $error("no answer one cycle after request");
  a_wait_single: assert property (!av_waitrequest |=> av_waitrequest)
    else $error("waitrequest low for more than a cycle");
  a_wait_idle: assert property (!av_req.read && !av_req.write |-> av_waitrequest)
    else $error("waitrequest low with no request");
  a_wait_cause: assert property ($fell(av_waitrequest) |-> $past(av_req.read || av_req.write))
    else $error("answer without a request");
  a_rdata_upper: assert property (!av_waitrequest |-> av_readdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_rdata_hold: assert property (!av_waitrequest |=> $stable(av_readdata))
    else $error("read data did not hold");
  a_rdata_moment: assert property ($changed(av_readdata) |-> !av_waitrequest)
    else $error("read data moved outside an answer");
  a_oe_follow: assert property (dir_wr |=> ##1 pin_oe == $past(av_req.writedata[2:0], 2))
    else $error("pin enable does not match direction write");
  a_oe_cause: assert property ($changed(pin_oe) |-> $past(dir_wr, 2))
    else $error("pin enable moved without direction write");
endmodule // dsp_timer_properties

bind dsp_timer dsp_timer_properties u_props (.clk(clk), .rst(rst), .av_req(av_req),
  .av_waitrequest(av_waitrequest), .av_readdata(av_readdata), .port_data(port_data),
  .pin_out(pin_out), .pin_oe(pin_oe));

/* File: test/dsp_load_model.sv */
`timescale 1ns/1ps
// Load on the compare pins: integrates how long each pin is seen high
module dsp_load_model
  import dsp_pkg::*;
(
  // Clock and window restart
  input wire logic clk,
  input wire logic clr,
  // Pins from the timer
  input wire logic [dsp_pkg::NCH-1:0] pin_out,
  input wire logic [dsp_pkg::NCH-1:0] pin_oe,
  // High time per pin, in clocks
  output int hi_cnt [dsp_pkg::NCH]
);
  // An undriven pin is pulled down at the load, so it never counts as high
  wire [NCH-1:0] level = pin_out & pin_oe;
  always @(posedge clk) begin
    for (int i = 0; i < NCH; i++) begin
      hi_cnt[i] <= clr ? 0 : hi_cnt[i] + int'(level[i]);
    end
  end
endmodule // dsp_load_model

/* File: test/dsp_timer_tb_top.sv */
`timescale 1ns/1ps
// Runs every dual-slope mode and compares pin duty and flags with a model
module dsp_timer_tb_top;
  import dsp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clr = 1'b0;
  dsp_av_req_t req = '0;
  logic [NCH-1:0] port_data = '0;
  logic av_waitrequest;
  logic [31:0] av_readdata;
  logic [NCH-1:0] pin_out;
  logic [NCH-1:0] pin_oe;
  int hi_cnt [NCH];
  int n_errors = 0;
  int checked = 0;
  logic [15:0] rd_q;
  // Mode table; a zero top means the top comes from a register
  logic [3:0] modes [7] = '{WGM_PC_8, WGM_PC_9, WGM_PC_10, WGM_PFC_CAP, WGM_PFC_CMPA,
    WGM_PC_CAP, WGM_PC_CMPA};
  logic [2:0] sels [7] = '{CS_DIV1, CS_DIV1, CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1};
  int facs [7] = '{1, 1, 1, 8, 64, 256, 1};
  logic [15:0] tops [7] = '{TOP_8, TOP_9, TOP_10, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

  initial begin
    forever #25 clk = ~clk;
  end

  dsp_timer dut (.clk(clk), .rst(rst), .av_req(req), .av_waitrequest(av_waitrequest),
    .av_readdata(av_readdata), .port_data(port_data), .pin_out(pin_out), .pin_oe(pin_oe));
  dsp_load_model load (.clk(clk), .clr(clr), .pin_out(pin_out), .pin_oe(pin_oe),
    .hi_cnt(hi_cnt));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One bus access; the request holds until waitrequest is seen low
  task automatic bus(input logic w, input logic [2:0] a, input logic [15:0] d);
    bit done;
    done = 0;
    @(posedge clk);
    req <= '{read: !w, write: w, address: a, writedata: {16'h0000, d}, byteenable: 4'hF};
    // Waitrequest is sampled on the rising edge only; the request stands until then
    for (int k = 0; k < 16 && !done; k++) begin
      @(posedge clk);
      done = (av_waitrequest === 1'b0);
    end
    if (!done) begin
      n_errors++;
      $display("unexpected at %0t: bus timeout", $time);
      tally_and_finish();
    end
    // Read data is taken at the answering edge, then the request drops
    rd_q = av_readdata[15:0];
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic run_mode(input int m);
    int t;
    int n;
    int p;
    int w [NCH];
    int e [NCH];
    logic [15:0] c [NCH];
    logic [1:0] cm [NCH];
    logic [2:0] pd;
    bit cmpa;
    bit cap;
    bit fix;
    cmpa = modes[m] inside {WGM_PFC_CMPA, WGM_PC_CMPA};
    cap = modes[m] inside {WGM_PFC_CAP, WGM_PC_CAP};
    fix = !cmpa && !cap;
    t = fix ? int'(tops[m]) : 3 + $urandom % 8;
    n = facs[m];
    p = 2 * t * n;
    pd = 3'($urandom);
    cm[0] = cmpa ? COM_TOG : COM_NINV;
    cm[1] = cmpa ? COM_NINV : COM_INV;
    cm[2] = cmpa ? COM_INV : COM_OFF;
    // Model: high clocks over two periods, from the match rules
    for (int i = 0; i < NCH; i++) begin
      w[i] = fix ? $urandom % 65536 : $urandom % (t + 1);
      if (i == 1) w[i] = (m % 2) ? t : 0;
      if (cmpa && i != 1) w[i] = (i == 0) ? t : t + 1;
      c[i] = fix ? 16'(w[i]) & 16'(t) : 16'(w[i]);
      e[i] = cm[i] == COM_TOG ? 2 * t * n : cm[i] == COM_NINV ? 4 * c[i] * n :
        cm[i] == COM_INV ? 4 * (t - c[i]) * n : pd[i] ? 4 * t * n : 0;
      if (cmpa && i == 2) e[i] = 0;
    end
    @(posedge clk);
    port_data <= pd;
    bus(1'b1, REG_CTRL, {2'h0, cm[2], cm[1], cm[0], 1'b0, sels[m], modes[m]});
    bus(1'b1, REG_CAPTOP, 16'(t));
    for (int i = 0; i < NCH; i++) bus(1'b1, 3'(REG_CMPA + i), 16'(w[i]));
    bus(1'b1, REG_PINDIR, cmpa ? 16'h0003 : 16'h0007);
    bus(1'b1, REG_COUNT, 16'h0000);
    for (int i = 0; i < NCH; i++) begin
      bus(1'b0, 3'(REG_CMPA + i), 16'h0000);
      chk(rd_q, c[i], "compare readback");
    end
    // Two periods let the buffered compares and the outputs settle
    repeat (2 * p + 8) @(posedge clk);
    bus(1'b1, REG_FLAGS, 16'h001F);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (2 * p) @(posedge clk);
    #1;
    for (int i = 0; i < NCH; i++) begin
      chk(hi_cnt[i], e[i], "pin high time");
    end
    bus(1'b0, REG_FLAGS, 16'h0000);
    chk(rd_q[4:0], {cap, !cmpa, 3'b111}, "flags");
    $display("test mode %0d done", modes[m]);
  endtask

  initial begin
    void'($urandom(32'hA41F));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      bus(1'b0, 3'(a), 16'h0000);
      chk(rd_q, RST_WORD, "reset value");
    end
    $display("test reset values done");
    for (int m = 0; m < 7; m++) run_mode(m);
    tally_and_finish();
  end
endmodule // dsp_timer_tb_top
